// File: include/iop_pkg.sv
// Shared constants for the configurable I/O port: register map, drive modes, reset values.
// Assumes a 32-bit APB register bus and one 20 MHz clock.
package iop_pkg;
  localparam int NPINS = 8;
  localparam int NPORTS = 2;
  // Drive select encodings
  typedef enum logic [2:0] {
    IOP_DM_HIZ_ANALOG = 3'h0,
    IOP_DM_HIZ_DIGITAL = 3'h1,
    IOP_DM_RES_PULLUP = 3'h2,
    IOP_DM_RES_PULLDOWN = 3'h3,
    IOP_DM_OD_LOW = 3'h4,
    IOP_DM_OD_HIGH = 3'h5,
    IOP_DM_STRONG = 3'h6,
    IOP_DM_RES_BOTH = 3'h7
  } iop_drive_t;
  // Edge selection per pin
  typedef enum logic [1:0] {
    IOP_EDGE_NONE = 2'h0,
    IOP_EDGE_RISE = 2'h1,
    IOP_EDGE_FALL = 2'h2,
    IOP_EDGE_BOTH = 2'h3
  } iop_edge_t;
  // Per-port register offsets (byte address = port base + offset)
  localparam logic [11:0] PORT_STRIDE = 12'h040;
  localparam logic [5:0] OFS_OUT_VALUE = 6'h00;
  localparam logic [5:0] OFS_PIN_LEVEL = 6'h04;
  localparam logic [5:0] OFS_DRIVE_SEL = 6'h08;
  localparam logic [5:0] OFS_BYPASS = 6'h0c;
  localparam logic [5:0] OFS_IN_ROUTE = 6'h10;
  localparam logic [5:0] OFS_EDGE_CFG = 6'h14;
  localparam logic [5:0] OFS_IRQ_STATUS = 6'h18;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h1c;
  localparam logic [5:0] OFS_SLEW = 6'h20;
  localparam logic [5:0] OFS_REGULATED = 6'h24;
  localparam logic [5:0] OFS_RESET_STATE = 6'h28;
  localparam logic [5:0] OFS_PIN_ACCESS = 6'h2c;
  // Per-pin access word: [2:0] drive, [3] out, [4] bypass, [5] in route, [7:6] edge, [8] slew
  localparam int PA_DRIVE_LSB = 0;
  localparam int PA_OUT_BIT = 3;
  localparam int PA_BYPASS_BIT = 4;
  localparam int PA_ROUTE_BIT = 5;
  localparam int PA_EDGE_LSB = 6;
  localparam int PA_SLEW_BIT = 8;
  localparam int PA_SEL_LSB = 16;
  // Values after reset
  localparam logic [2:0] DRIVE_RESET = 3'h1;
  localparam logic [7:0] OUT_RESET = 8'h00;
endpackage

// File: include/iop_pin_if.sv
// Carrier between the port top and its per-port pin drive and edge logic.
// Assumes all signals in the ref_clk domain.
`timescale 1ns/1ps
interface iop_pin_if #(parameter int N = 8);
  logic [N-1:0] out_val;    // Selected output value
  logic [3*N-1:0] drive;    // Drive select per pin
  logic [N-1:0] regulated;  // Special pin regulated mode
  logic [N-1:0] usb_pin;    // Pin is usb capable
  logic [N-1:0] pin_sync;   // Synchronised pin level
  logic [2*N-1:0] edge_cfg; // Edge selection per pin
  logic [N-1:0] edge_hit;   // One-cycle edge pulse per pin
  modport ctrl (output out_val, drive, regulated, usb_pin, pin_sync, edge_cfg, input edge_hit);
  modport drv (input out_val, drive, regulated, usb_pin);
  modport det (input pin_sync, edge_cfg, output edge_hit);
endinterface

// File: logic/iop_drive.sv
// Per-pin output driver: turns drive select and output value into pad controls.
// Assumes pad resolves strong/resistive enables; inputs are registered except fabric output in bypass.
`timescale 1ns/1ps
module iop_drive #(
  parameter int N = 8
) (
  iop_pin_if.drv pif,                // Pin controls
  output logic [N-1:0] pad_out,      // Level driven on pad
  output logic [N-1:0] pad_oe,       // Strong drive enable
  output logic [N-1:0] pad_pu,       // Resistive pull-up enable
  output logic [N-1:0] pad_pd        // Resistive pull-down enable
);
  // One decoder per pin
  for (genvar i = 0; i < N; i++) begin : g_pin
    iop_pkg::iop_drive_t dm;
    logic v;
    assign dm = iop_pkg::iop_drive_t'(pif.usb_pin[i] ? iop_pkg::IOP_DM_STRONG : pif.drive[3*i +: 3]);
    assign v = pif.out_val[i];
    always_comb begin
      pad_out[i] = v;
      pad_oe[i] = 1'b0;
      pad_pu[i] = 1'b0;
      pad_pd[i] = 1'b0;
      unique case (dm)
        iop_pkg::IOP_DM_HIZ_ANALOG, iop_pkg::IOP_DM_HIZ_DIGITAL: pad_oe[i] = 1'b0;
        iop_pkg::IOP_DM_RES_PULLUP: begin
          pad_oe[i] = ~v;
          pad_pu[i] = v & ~pif.regulated[i];
        end
        iop_pkg::IOP_DM_RES_PULLDOWN: begin
          pad_oe[i] = v;
          pad_pd[i] = ~v & ~pif.regulated[i];
        end
        iop_pkg::IOP_DM_OD_LOW: pad_oe[i] = ~v;
        iop_pkg::IOP_DM_OD_HIGH: pad_oe[i] = v;
        iop_pkg::IOP_DM_STRONG: pad_oe[i] = 1'b1;
        iop_pkg::IOP_DM_RES_BOTH: begin
          pad_pu[i] = v & ~pif.regulated[i];
          pad_pd[i] = ~v & ~pif.regulated[i];
        end
      endcase
    end
  end
endmodule

// File: logic/iop_edge.sv
// Per-pin edge detector on synchronised pin levels.
// Assumes pin_sync already passed a two-flop synchroniser.
`timescale 1ns/1ps
module iop_edge #(
  parameter int N = 8
) (
  input wire logic ref_clk,  // System clock
  input wire logic rst,      // Synchronous reset, active high
  iop_pin_if.det pif         // Level in, edge pulses out
);
  logic [N-1:0] prev_q;
  // Previous level; tracks the pin through reset so no false edge follows it
  always_ff @(posedge ref_clk) begin
    prev_q <= pif.pin_sync;
  end
  // Rise, fall or both, per pin
  for (genvar i = 0; i < N; i++) begin : g_pin
    logic rise, fall;
    assign rise = pif.pin_sync[i] & ~prev_q[i];
    assign fall = ~pif.pin_sync[i] & prev_q[i];
    assign pif.edge_hit[i] = (pif.edge_cfg[2*i] & rise) | (pif.edge_cfg[2*i+1] & fall);
  end
endmodule

// File: logic/iop_port.sv
// Configurable I/O ports: APB registers, per-pin drive, input capture and edge interrupts.
// Assumes an APB master on ref_clk and asynchronous pad inputs.
// Functional notes
// - Three-bit drive select for every pin
// - Output from fabric in bypass, else register
// - Pin level always captured; fabric gated
// - Modes 000 and 001 leave pin undriven
// - 010 resistive high/strong low; 011 reverse
// - Mode 100 open drain driving low
// - Mode 101 open drain driving high
// - Mode 111 resistive high and low
// - No resistive modes in regulated mode
// - Rising, falling or both edge interrupts
// - One interrupt output per port
// - Separate pin level and output registers
// - Whole-port and per-pin register access
// - Drive modes reset to fixed 001, not loaded from reset setting
// - Slew-rate control per pin
// - Usb capable pins push-pull only
// - Pins usable as input and output
`timescale 1ns/1ps
module iop_port #(
  parameter int N = iop_pkg::NPINS,
  parameter int P = iop_pkg::NPORTS,
  parameter logic [N-1:0] USB_PINS = '0
) (
  input wire logic ref_clk,              // System clock, 20 MHz
  input wire logic rst,                  // Synchronous reset, active high
  input wire logic psel,                 // APB select
  input wire logic penable,              // APB enable
  input wire logic pwrite,               // APB direction
  input wire logic [11:0] paddr,         // APB byte address
  input wire logic [31:0] pwdata,        // APB write data
  output logic [31:0] prdata,            // APB read data
  output logic pready,                   // APB ready
  output logic pslverr,                  // APB error
  input wire logic [P*N-1:0] pad_in,     // Asynchronous pad levels
  output logic [P*N-1:0] pad_out,        // Pad output level
  output logic [P*N-1:0] pad_oe,         // Strong drive enable
  output logic [P*N-1:0] pad_pu,         // Resistive pull-up
  output logic [P*N-1:0] pad_pd,         // Resistive pull-down
  output logic [P*N-1:0] pad_slew,       // Slew-limited drive
  input wire logic [P*N-1:0] fabric_out, // Routing fabric output values
  output logic [P*N-1:0] fabric_in,      // Pin levels to routing fabric
  output logic [P-1:0] port_irq          // Per-port interrupt, level
);
  logic wr_en, rd_en, hit;
  logic [31:0] rd_d;
  logic [31:0] prdata_q;        // Read word held through the access phase
  logic [P-1:0][31:0] port_rd;  // Readback word of each port
  logic [5:0] ofs;
  logic [11:0] port_sel;
  assign ofs = paddr[5:0];
  assign port_sel = paddr / iop_pkg::PORT_STRIDE;
  assign hit = (port_sel < 12'(P)) && (paddr[1:0] == 2'h0) && (ofs <= iop_pkg::OFS_PIN_ACCESS);
  assign wr_en = psel & penable & pwrite & hit;
  // Read word is captured in the setup phase
  assign rd_en = psel & ~penable & ~pwrite;
  // Zero-wait APB; unmapped answers with error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  logic [P*N-1:0] s1_q, s2_q;
  // Two-flop synchroniser, first stage; no reset so it tracks the pin
  always_ff @(posedge ref_clk) begin
    s1_q <= pad_in;
  end

  // Second stage; keeps idle-high pins from showing a false edge after reset
  always_ff @(posedge ref_clk) begin
    s2_q <= s1_q;
  end

  for (genvar p = 0; p < P; p++) begin : g_port
    logic [N-1:0] out_q;      // Port output value
    logic [N-1:0] byp_q;      // Fabric bypass per pin
    logic [N-1:0] route_q;    // Pin level to fabric enable
    logic [N-1:0] slew_q;     // Slew-limited drive
    logic [N-1:0] reg_q;      // Regulated special pin mode
    logic [N-1:0] st_q;       // Sticky edge pending flags
    logic [N-1:0] msk_q;      // Interrupt mask
    logic [N-1:0] lvl_q;      // Captured pin level
    logic [3*N-1:0] dm_q;     // Drive select per pin
    logic [3*N-1:0] rst_dm_q; // Programmed reset drive setting
    logic [2*N-1:0] edge_q;   // Edge selection per pin
    logic sel;                // Write to this port
    logic pin_wr;             // Per-pin access write to this port
    logic [N-1:0] pin_mask;   // One-hot pin of a per-pin write
    logic [31:0] rd_w;        // Readback word of this port
    iop_pin_if #(.N(N)) pif ();
    assign sel = wr_en && (port_sel == 12'(p));
    assign pin_wr = sel && (ofs == iop_pkg::OFS_PIN_ACCESS);
    assign pin_mask = N'(1) << pwdata[iop_pkg::PA_SEL_LSB +: 3];

    // Output value: whole port or one pin
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        out_q <= N'(iop_pkg::OUT_RESET);
      end else if (sel && ofs == iop_pkg::OFS_OUT_VALUE) begin
        out_q <= pwdata[N-1:0];
      end else if (pin_wr) begin
        out_q <= (out_q & ~pin_mask) | ({N{pwdata[iop_pkg::PA_OUT_BIT]}} & pin_mask);
      end
    end

    // Drive select: whole port or one pin's field
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        dm_q <= {N{iop_pkg::DRIVE_RESET}};
      end else if (sel && ofs == iop_pkg::OFS_DRIVE_SEL) begin
        dm_q <= pwdata[3*N-1:0];
      end else if (pin_wr) begin
        for (int i = 0; i < N; i++) begin
          if (pin_mask[i]) begin
            dm_q[3*i +: 3] <= pwdata[iop_pkg::PA_DRIVE_LSB +: 3];
          end
        end
      end
    end

    // Fabric bypass of the output value
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        byp_q <= '0;
      end else if (sel && ofs == iop_pkg::OFS_BYPASS) begin
        byp_q <= pwdata[N-1:0];
      end else if (pin_wr) begin
        byp_q <= (byp_q & ~pin_mask) | ({N{pwdata[iop_pkg::PA_BYPASS_BIT]}} & pin_mask);
      end
    end

    // Pin level routing to the fabric
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        route_q <= '0;
      end else if (sel && ofs == iop_pkg::OFS_IN_ROUTE) begin
        route_q <= pwdata[N-1:0];
      end else if (pin_wr) begin
        route_q <= (route_q & ~pin_mask) | ({N{pwdata[iop_pkg::PA_ROUTE_BIT]}} & pin_mask);
      end
    end

    // Edge selection, two bits per pin
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        edge_q <= '0;
      end else if (sel && ofs == iop_pkg::OFS_EDGE_CFG) begin
        edge_q <= pwdata[2*N-1:0];
      end else if (pin_wr) begin
        for (int i = 0; i < N; i++) begin
          if (pin_mask[i]) begin
            edge_q[2*i +: 2] <= pwdata[iop_pkg::PA_EDGE_LSB +: 2];
          end
        end
      end
    end

    // Interrupt mask, whole port only
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        msk_q <= '0;
      end else if (sel && ofs == iop_pkg::OFS_IRQ_MASK) begin
        msk_q <= pwdata[N-1:0];
      end
    end

    // Slew-limited drive per pin
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        slew_q <= '0;
      end else if (sel && ofs == iop_pkg::OFS_SLEW) begin
        slew_q <= pwdata[N-1:0];
      end else if (pin_wr) begin
        slew_q <= (slew_q & ~pin_mask) | ({N{pwdata[iop_pkg::PA_SLEW_BIT]}} & pin_mask);
      end
    end

    // Regulated output mode of special pins
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        reg_q <= '0;
      end else if (sel && ofs == iop_pkg::OFS_REGULATED) begin
        reg_q <= pwdata[N-1:0];
      end
    end

    // Programmable reset drive setting; not cleared by reset so it survives it
    always_ff @(posedge ref_clk) begin
      if (sel && ofs == iop_pkg::OFS_RESET_STATE) begin
        rst_dm_q <= pwdata[3*N-1:0];
      end
    end

    // Pin level register, separate from output value
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        lvl_q <= '0;
      end else begin
        lvl_q <= s2_q[p*N +: N];
      end
    end

    // Sticky pending flags; set wins over write-one clear
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        st_q <= '0;
      end else begin
        st_q <= (st_q & ~((sel && ofs == iop_pkg::OFS_IRQ_STATUS) ? pwdata[N-1:0] : '0))
                | pif.edge_hit;
      end
    end

    assign pif.out_val = (byp_q & fabric_out[p*N +: N]) | (~byp_q & out_q);
    assign pif.drive = dm_q;
    assign pif.regulated = reg_q;
    assign pif.usb_pin = USB_PINS;
    assign pif.pin_sync = s2_q[p*N +: N];
    assign pif.edge_cfg = edge_q;
    assign fabric_in[p*N +: N] = lvl_q & route_q;
    assign pad_slew[p*N +: N] = slew_q & ~USB_PINS;
    assign port_irq[p] = |(st_q & msk_q);

    // Readback word of this port; pin level kept apart from output value
    always_comb begin
      rd_w = '0;
      unique case (ofs)
        iop_pkg::OFS_OUT_VALUE: rd_w[N-1:0] = out_q;
        iop_pkg::OFS_PIN_LEVEL: rd_w[N-1:0] = lvl_q;
        iop_pkg::OFS_DRIVE_SEL: rd_w[3*N-1:0] = dm_q;
        iop_pkg::OFS_BYPASS: rd_w[N-1:0] = byp_q;
        iop_pkg::OFS_IN_ROUTE: rd_w[N-1:0] = route_q;
        iop_pkg::OFS_EDGE_CFG: rd_w[2*N-1:0] = edge_q;
        iop_pkg::OFS_IRQ_STATUS: rd_w[N-1:0] = st_q;
        iop_pkg::OFS_IRQ_MASK: rd_w[N-1:0] = msk_q;
        iop_pkg::OFS_SLEW: rd_w[N-1:0] = slew_q;
        iop_pkg::OFS_REGULATED: rd_w[N-1:0] = reg_q;
        iop_pkg::OFS_RESET_STATE: rd_w[3*N-1:0] = rst_dm_q;
        default: ;
      endcase
    end
    assign port_rd[p] = rd_w;

    iop_drive #(.N(N)) u_drive (
      .pif(pif.drv),
      .pad_out(pad_out[p*N +: N]),
      .pad_oe(pad_oe[p*N +: N]),
      .pad_pu(pad_pu[p*N +: N]),
      .pad_pd(pad_pd[p*N +: N])
    );
    iop_edge #(.N(N)) u_edge (
      .ref_clk(ref_clk),
      .rst(rst),
      .pif(pif.det)
    );
  end

  // Select the addressed port's word
  always_comb begin
    rd_d = '0;
    for (int p = 0; p < P; p++) begin
      if (port_sel == 12'(p)) begin
        rd_d = port_rd[p];
      end
    end
  end

  // Read data taken in the setup phase, stands through the access phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata_q <= '0;
    end else if (rd_en) begin
      prdata_q <= rd_d;
    end
  end
  assign prdata = prdata_q;
endmodule

// File: bench/iop_pad_model.sv
// Board nets at the port pads: strong drivers, pulls and an external source.
// Assumes pad controls from iop_port; ext wins only on undriven, unpulled nets.
`timescale 1ns/1ps
module iop_pad_model #(
  parameter int W = 16
) (
  input wire logic [W-1:0] pad_out, // Driven level
  input wire logic [W-1:0] pad_oe,  // Strong enable
  input wire logic [W-1:0] pad_pu,  // Pull-up
  input wire logic [W-1:0] pad_pd,  // Pull-down
  input wire logic [W-1:0] ext,     // External source
  output logic [W-1:0] pad_in       // Net level
);
  // Strong beats resistive beats external
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (pad_pu[i]) pad_in[i] = 1'b1;
      else if (pad_pd[i]) pad_in[i] = 1'b0;
      else pad_in[i] = ext[i];
    end
  end
endmodule

// File: bench/iop_port_props.sv
// Checker on pad controls, fabric levels and port interrupts.
// Assumes binding to iop_port; outputs settle within six quiet cycles.
`timescale 1ns/1ps
module iop_port_props #(
  parameter int N = 8,
  parameter int P = 2
) (
  input wire logic ref_clk,              // Clock
  input wire logic rst,                  // Reset
  input wire logic psel,                 // APB select
  input wire logic [P*N-1:0] pad_in,     // Pad levels
  input wire logic [P*N-1:0] pad_out,    // Pad level out
  input wire logic [P*N-1:0] pad_oe,     // Strong enable
  input wire logic [P*N-1:0] pad_pu,     // Pull-up
  input wire logic [P*N-1:0] pad_pd,     // Pull-down
  input wire logic [P*N-1:0] fabric_out, // Fabric values
  input wire logic [P*N-1:0] fabric_in,  // Levels to fabric
  input wire logic [P-1:0] port_irq      // Port interrupts
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [3:0] quiet_q;
  // Cycles without bus, pad or fabric activity
  always_ff @(posedge ref_clk) begin
    if (rst || psel || $changed(pad_in) || $changed(fabric_out)) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end
  no_pull_both_a: assert property (!(pad_pu & pad_pd)) else $error("pull-up and pull-down together");
  strong_pull_a: assert property ((pad_oe & (pad_pu | pad_pd)) == '0) else $error("strong with pull");
  reset_hiz_a: assert property ($fell(rst) |-> (pad_oe | pad_pu | pad_pd) == '0) else $error("driven after reset");
  quiet_irq_a: assert property (quiet_q > 4'h6 |-> $stable(port_irq)) else $error("irq moved while quiet");
  quiet_oe_a: assert property (quiet_q > 4'h6 |-> $stable(pad_oe)) else $error("drive moved while quiet");
  quiet_pull_a: assert property (quiet_q > 4'h6 |-> $stable(pad_pu | pad_pd)) else $error("pull moved");
  quiet_fab_a: assert property (quiet_q > 4'h6 |-> $stable(fabric_in)) else $error("fabric moved");
  quiet_out_a: assert property (quiet_q > 4'h6 |-> $stable(pad_out)) else $error("pad out moved");
endmodule
bind iop_port iop_port_props #(.N(N), .P(P)) i_props (.ref_clk(ref_clk), .rst(rst), .psel(psel),
  .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd),
  .fabric_out(fabric_out), .fabric_in(fabric_in), .port_irq(port_irq));

// File: bench/iop_port_tb.sv
// Bench for iop_port: drive modes, bypass, input capture, edge interrupts, pin access.
// Assumes iop_pad_model on the pads and an APB master inside this module.
`timescale 1ns/1ps
module iop_port_tb;
  logic ref_clk = 1'b0;
  logic rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic err_v;
  logic [15:0] pad_in, pad_out, pad_oe, pad_pu, pad_pd, pad_slew, fabric_out, fabric_in, ext;
  logic [1:0] port_irq;
  int failures = 0;
  int compares = 0;
  // Strong, pull-up, pull-down per mode and value
  logic [2:0] dm_exp [16] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h2, 3'h1, 3'h4,
    3'h4, 3'h0, 3'h0, 3'h4, 3'h4, 3'h4, 3'h1, 3'h2};
  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;
  iop_port i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd),
    .pad_slew(pad_slew), .fabric_out(fabric_out), .fabric_in(fabric_in), .port_irq(port_irq));
  iop_pad_model i_pads (.pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd),
    .ext(ext), .pad_in(pad_in));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One APB transfer, held until pready, then one idle cycle
  task automatic apb(input logic w, input logic [5:0] o, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {6'h00, o};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd_v = prdata;
    err_v = pslverr;
    if (pready !== 1'b1) check("pready", pready, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [5:0] o, input logic [31:0] d);
    apb(1'b1, o, d);
  endtask
  task automatic rd(input logic [5:0] o);
    apb(1'b0, o, 32'h0);
  endtask
  task automatic t_reset();
    rd(iop_pkg::OFS_DRIVE_SEL);
    check("drive reset", rd_v, {8'h00, {8{iop_pkg::DRIVE_RESET}}});
    rd(iop_pkg::OFS_OUT_VALUE);
    check("out reset", rd_v, {24'h0, iop_pkg::OUT_RESET});
    rd(6'h3c);
    check("unmapped error", err_v, 1'b1);
    rd(iop_pkg::OFS_DRIVE_SEL);
    check("mapped no error", err_v, 1'b0);
  endtask
  task automatic t_modes();
    logic [2:0] e;
    for (int m = 0; m < 16; m++) begin
      e = dm_exp[m];
      wr(iop_pkg::OFS_DRIVE_SEL, {8'h00, {8{m[3:1]}}});
      wr(iop_pkg::OFS_OUT_VALUE, {24'h0, {8{m[0]}}});
      wt(3);
      check("oe", pad_oe[7:0], {8{e[2]}});
      check("pu", pad_pu[7:0], {8{e[1]}});
      check("pd", pad_pd[7:0], {8{e[0]}});
      if (e[2]) check("out", pad_out[7:0], {8{m[0]}});
    end
    wr(iop_pkg::OFS_REGULATED, 32'hff);
    wt(3);
    check("regulated pulls", pad_pu[7:0] | pad_pd[7:0], 8'h00);
    wr(iop_pkg::OFS_REGULATED, 32'h0);
    wr(iop_pkg::OFS_SLEW, 32'h0f);
    wt(3);
    check("slew", pad_slew[7:0], 8'h0f);
  endtask
  task automatic t_bypass();
    wr(iop_pkg::OFS_DRIVE_SEL, {8'h00, {8{3'h6}}});
    wr(iop_pkg::OFS_OUT_VALUE, 32'h0);
    wr(iop_pkg::OFS_BYPASS, 32'hff);
    fabric_out <= 16'h00a5;
    wt(3);
    check("bypass out", pad_out[7:0], 8'ha5);
    wr(iop_pkg::OFS_BYPASS, 32'h0);
    wt(3);
    check("register out", pad_out[7:0], 8'h00);
  endtask
  task automatic t_input();
    wr(iop_pkg::OFS_DRIVE_SEL, {8'h00, {8{3'h1}}});
    wr(iop_pkg::OFS_OUT_VALUE, 32'hc3);
    ext <= 16'h003c;
    wt(4);
    rd(iop_pkg::OFS_PIN_LEVEL);
    check("pin level", rd_v, 32'h3c);
    wr(iop_pkg::OFS_IN_ROUTE, 32'h0);
    wt(3);
    check("fabric gated", fabric_in[7:0], 8'h00);
    wr(iop_pkg::OFS_IN_ROUTE, 32'hff);
    wt(3);
    check("fabric in", fabric_in[7:0], 8'h3c);
  endtask
  task automatic t_edges();
    ext <= 16'h0000;
    wr(iop_pkg::OFS_EDGE_CFG, 32'h39);
    wr(iop_pkg::OFS_IRQ_MASK, 32'hff);
    wt(6);
    wr(iop_pkg::OFS_IRQ_STATUS, 32'hff);
    ext <= 16'h00ff;
    wt(10);
    check("irq rise", port_irq, 2'b01);
    rd(iop_pkg::OFS_IRQ_STATUS);
    check("rise status", rd_v, 32'h05);
    wr(iop_pkg::OFS_IRQ_STATUS, 32'h01);
    rd(iop_pkg::OFS_IRQ_STATUS);
    check("one clear", rd_v, 32'h04);
    wr(iop_pkg::OFS_IRQ_STATUS, 32'h04);
    wt(2);
    check("irq clear", port_irq, 2'b00);
    ext <= 16'h0000;
    wt(10);
    rd(iop_pkg::OFS_IRQ_STATUS);
    check("fall status", rd_v, 32'h06);
    wr(iop_pkg::OFS_IRQ_MASK, 32'h0);
    wt(2);
    check("irq masked", port_irq, 2'b00);
    rd(iop_pkg::OFS_IRQ_STATUS);
    check("sticky status", rd_v, 32'h06);
  endtask
  task automatic t_pin();
    wr(iop_pkg::OFS_PIN_ACCESS, (32'h3 << iop_pkg::PA_SEL_LSB) | (32'h6 << iop_pkg::PA_DRIVE_LSB)
      | (32'h1 << iop_pkg::PA_OUT_BIT));
    rd(iop_pkg::OFS_DRIVE_SEL);
    check("pin drive", rd_v[11:6], 6'h31);
    rd(iop_pkg::OFS_OUT_VALUE);
    check("pin out", rd_v[3], 1'b1);
  endtask
  // Main sequence
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, fabric_out, ext} = {4'h8, 76'h0};
    wt(3);
    rst <= 1'b0;
    wt(1);
    t_reset();
    t_modes();
    t_bypass();
    t_input();
    t_edges();
    t_pin();
    complete_run();
  end
  // Watchdog
  initial begin
    #1000000;
    failures++;
    complete_run();
  end
endmodule
